// >>> hdl/csm_top.sv
// Three-channel 3x3 matrix multiplier with coefficient store and output buffer
`timescale 1ns/100ps
module csm_top #(
  parameter int DATA_W = csm_pkg::DATA_W,
  parameter int COEF_W = csm_pkg::COEF_W
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Coefficient load
  input wire logic [1:0] coef_write_select,
  input wire logic [COEF_W-1:0] coef_port_first,
  input wire logic [COEF_W-1:0] coef_port_second,
  input wire logic [COEF_W-1:0] coef_port_third,
  // Input pixel stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] data_in_first,
  input wire logic [DATA_W-1:0] data_in_second,
  input wire logic [DATA_W-1:0] data_in_third,
  // Result stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] result_first,
  output logic [DATA_W-1:0] result_second,
  output logic [DATA_W-1:0] result_third
);
  // The arithmetic is built for the documented word sizes only
  if (DATA_W != csm_pkg::DATA_W || COEF_W != csm_pkg::COEF_W)
  begin : g_chk
    $error("csm_top: only 12-bit data and 10-bit coefficients are supported");
  end

  localparam int N = csm_pkg::LANES;
  localparam int PW = csm_pkg::PROD_W;
  localparam int SW = csm_pkg::SUM_W;

  // Signed product of a data word and a fractional coefficient
  function automatic logic signed [PW-1:0] mul(input logic [DATA_W-1:0] d, input logic [COEF_W-1:0] k);
    logic signed [PW-1:0] dx; // Operands widened first so the product is not cut to operand width
    logic signed [PW-1:0] kx;
    dx = PW'($signed(d));
    kx = PW'($signed(k));
    mul = dx * kx; // RULE_08 RULE_09
  endfunction

  // Sum of three products, kept at full internal width
  function automatic logic signed [SW-1:0] add3(input logic signed [PW-1:0] p0, input logic signed [PW-1:0] p1,
                                                input logic signed [PW-1:0] p2);
    add3 = SW'(p0) + SW'(p1) + SW'(p2);
  endfunction

  // Round half up, then drop the fractional bits
  function automatic logic [DATA_W-1:0] rnd(input logic signed [SW-1:0] s);
    logic [SW-1:0] t;
    t = s + csm_pkg::ROUND_HALF;
    rnd = t[csm_pkg::FRAC_W +: DATA_W]; // RULE_10
  endfunction

  logic [COEF_W-1:0] coef_in [N]; // Coefficient ports by index
  logic [DATA_W-1:0] dat_in [N]; // Data ports by index
  logic [COEF_W-1:0] coef_reg [N][N]; // Stored coefficients [port][output group]
  logic [COEF_W-1:0] coef_next [N][N]; // Values the store holds after this edge
  logic adv; // Pipeline moves on this edge
  logic acc; // Input word captured on this edge
  logic v_s1, v_s2, v_s3, v_s4; // Stage valid flags
  logic [DATA_W-1:0] dat_s1 [N]; // Captured data
  logic [COEF_W-1:0] k_s1 [N][N]; // Coefficients paired with the captured data
  logic signed [PW-1:0] prod_next [N][N]; // Nine products
  logic signed [PW-1:0] prod_s2 [N][N];
  logic signed [SW-1:0] sum_next [N]; // Three dot products
  logic signed [SW-1:0] sum_s3 [N];
  logic [DATA_W-1:0] res_next [N]; // Rounded results
  logic [DATA_W-1:0] res_s4 [N];
  logic [csm_pkg::RES_W-1:0] buf_in_data;
  logic [csm_pkg::RES_W-1:0] buf_out_data;

  assign coef_in[0] = coef_port_first; // RULE_04
  assign coef_in[1] = coef_port_second;
  assign coef_in[2] = coef_port_third;
  assign dat_in[0] = data_in_first; // RULE_05
  assign dat_in[1] = data_in_second;
  assign dat_in[2] = data_in_third;

  // The whole pipeline stalls together when the output buffer is full
  assign adv = in_ready;
  assign acc = in_valid && adv;

  // Each port updates only its own register of the selected group; select zero holds all
  for (genvar p = 0; p < N; p++)
  begin : g_port
    for (genvar g = 0; g < N; g++)
    begin : g_grp
      assign coef_next[p][g] = (coef_write_select == 2'(g + 1)) ? coef_in[p] : coef_reg[p][g]; // RULE_02 RULE_03 RULE_11
      assign prod_next[p][g] = mul(dat_s1[p], k_s1[p][g]); // RULE_07
    end
    assign sum_next[p] = add3(prod_s2[0][p], prod_s2[1][p], prod_s2[2][p]); // RULE_07 RULE_10
    assign res_next[p] = rnd(sum_s3[p]); // RULE_10
  end

  // Coefficient store; loads continue even while the data path is stalled
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < N; p++)
        for (int g = 0; g < N; g++)
          coef_reg[p][g] <= csm_pkg::COEF_RST;
    end
    else
      coef_reg <= coef_next; // RULE_01
  end

  // Stage valid chain
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      v_s1 <= 1'b0;
      v_s2 <= 1'b0;
      v_s3 <= 1'b0;
      v_s4 <= 1'b0;
    end
    else if (adv)
    begin
      v_s1 <= in_valid;
      v_s2 <= v_s1;
      v_s3 <= v_s2;
      v_s4 <= v_s3;
    end
  end

  // Data stages; a captured word pairs with the coefficients written on the same edge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < N; i++)
      begin
        dat_s1[i] <= csm_pkg::DATA_RST;
        sum_s3[i] <= '0;
        res_s4[i] <= csm_pkg::DATA_RST;
        for (int j = 0; j < N; j++)
        begin
          k_s1[i][j] <= csm_pkg::COEF_RST;
          prod_s2[i][j] <= '0;
        end
      end
    end
    else if (adv)
    begin
      dat_s1 <= dat_in; // RULE_05
      k_s1 <= coef_next; // RULE_07
      prod_s2 <= prod_next;
      sum_s3 <= sum_next;
      res_s4 <= res_next;
    end
  end

  // Fifth stage is the buffer head, so results leave registered after five edges
  assign buf_in_data = {res_s4[2], res_s4[1], res_s4[0]};

  csm_pair_buf #(
    .WIDTH(csm_pkg::RES_W)
  ) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(v_s4 && adv),
    .in_ready(in_ready),
    .in_data(buf_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out_data)
  );

  // Result ports are bits of the buffer head register
  assign result_first = buf_out_data[csm_pkg::RES_FIRST_LSB +: DATA_W]; // RULE_06
  assign result_second = buf_out_data[csm_pkg::RES_SECOND_LSB +: DATA_W];
  assign result_third = buf_out_data[csm_pkg::RES_THIRD_LSB +: DATA_W];

  // Helper: expected result from the inputs and coefficients of the capture edge
  logic [DATA_W-1:0] exp_res [N];
  for (genvar o = 0; o < N; o++)
  begin : g_exp
    assign exp_res[o] = rnd(add3(mul(dat_in[0], coef_next[0][o]), mul(dat_in[1], coef_next[1][o]),
                                 mul(dat_in[2], coef_next[2][o])));
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // A word reaches the head only if the buffer was empty or drained on the pushing edge
  sequence res_path_s;
    acc ##1 in_ready [*3] ##1 (in_ready && (!out_valid || out_ready));
  endsequence

  coef_hold_a: assert property ((coef_write_select == csm_pkg::SEL_HOLD) |=> $stable(coef_reg[0][0]) // RULE_11
    && $stable(coef_reg[1][1]) && $stable(coef_reg[2][2]) && $stable(coef_reg[0][2]))
    else $error("coefficients changed under hold select");
  coef_load_a: assert property ((coef_write_select != csm_pkg::SEL_HOLD) |=> // RULE_03
    coef_reg[0][$past(coef_write_select) - 2'h1] == $past(coef_port_first)
    && coef_reg[1][$past(coef_write_select) - 2'h1] == $past(coef_port_second)
    && coef_reg[2][$past(coef_write_select) - 2'h1] == $past(coef_port_third))
    else $error("selected coefficient group not loaded");
  coef_group_other_a: assert property ((coef_write_select == csm_pkg::SEL_FIRST) |=> // RULE_02
    $stable(coef_reg[0][1]) && $stable(coef_reg[1][2]) && $stable(coef_reg[2][1]) && $stable(coef_reg[0][2]))
    else $error("unselected coefficient group changed");
  coef_group_third_a: assert property ((coef_write_select == 2'h3) |=> // RULE_02
    $stable(coef_reg[0][0]) && $stable(coef_reg[1][1]) && $stable(coef_reg[2][0]) && $stable(coef_reg[1][0]))
    else $error("unselected coefficient group changed");
  pipe_latency_a: assert property ((acc ##1 in_ready [*4]) |=> out_valid) // RULE_07
    else $error("result not valid five cycles after capture");
  result_first_a: assert property (res_path_s |=> result_first == $past(exp_res[0], 5)) // RULE_10
    else $error("first result wrong");
  result_second_a: assert property (res_path_s |=> result_second == $past(exp_res[1], 5)) // RULE_08
    else $error("second result wrong");
  result_third_a: assert property (res_path_s |=> result_third == $past(exp_res[2], 5)) // RULE_09
    else $error("third result wrong");
  stall_hold_a: assert property ((out_valid && !out_ready) |=> out_valid && $stable(result_first) // RULE_06
    && $stable(result_second) && $stable(result_third))
    else $error("result lost during receiver stall");

  load_seen_c: cover property (coef_write_select != csm_pkg::SEL_HOLD ##1 acc);
  buffer_full_c: cover property (out_valid && !out_ready ##1 !in_ready);
  stream_c: cover property ((out_valid && out_ready) [*3]);
  full_load_c: cover property (coef_write_select == 2'h1 ##1 coef_write_select == 2'h2 ##1 coef_write_select == 2'h3);
endmodule

// >>> hdl/csm_pkg.sv
// Shared constants for the three-channel colorspace matrix multiplier
// Behaviour
// (RULE_01) Everything runs on one rising clock edge.
// (RULE_02) Write select picks one coefficient group, or none.
// (RULE_03) Each coefficient port loads one register of its own.
// (RULE_04) Coefficient ports are ten bits wide.
// (RULE_05) Three 12-bit data words captured every edge. Code captures only on edges with in_ready high.
// (RULE_06) Results come from registers, new each edge. Code changes them only when a word reaches the buffer head.
// (RULE_07) Result is three-term dot product, five cycles later. Code takes longer when the receiver stalls.
// (RULE_08) Data and results are 12-bit two's complement.
// (RULE_09) Coefficients are sign-unit, nine fractional bits.
// (RULE_10) Full precision; round 23-bit sum to 12 bits at the end.
// (RULE_11) Select zero holds; one to three load groups.
package csm_pkg;
  // Word widths
  localparam int DATA_W = 12;
  localparam int COEF_W = 10;
  localparam int FRAC_W = 9;
  localparam int PROD_W = DATA_W + COEF_W;
  localparam int SUM_W = 23;
  localparam int LANES = 3;
  // Pipeline depth from capture to result port
  localparam int PIPE_LAT = 5;
  // Entries of the output buffer
  localparam int BUF_DEPTH = 2;
  // Field positions of the packed result word
  localparam int RES_FIRST_LSB = 0;
  localparam int RES_SECOND_LSB = DATA_W;
  localparam int RES_THIRD_LSB = 2 * DATA_W;
  localparam int RES_W = LANES * DATA_W;
  // Write select codes
  localparam logic [1:0] SEL_HOLD = 2'h0;
  localparam logic [1:0] SEL_FIRST = 2'h1;
  // Reset values
  localparam logic [COEF_W-1:0] COEF_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
  // Half an output LSB in the internal sum, for round-half-up
  localparam logic [SUM_W-1:0] ROUND_HALF = 23'h000100;
endpackage

// >>> hdl/csm_pair_buf.sv
// Two-entry output buffer whose head entry drives the outputs directly
`timescale 1ns/100ps
module csm_pair_buf #(
  parameter int WIDTH = 36
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Refuse widths the storage cannot hold
  if (WIDTH < 1)
  begin : g_chk
    $error("csm_pair_buf: WIDTH must be at least 1");
  end

  logic [1:0] count_reg; // Words held, 0 to 2
  logic [1:0] count_next;
  logic [WIDTH-1:0] slot_reg [csm_pkg::BUF_DEPTH]; // Slot 0 is the head
  logic push; // Word taken on this edge
  logic pop; // Word leaves on this edge

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
  assign out_data = slot_reg[0];

  // Occupancy and registered handshake flags; ready is precomputed so it is a flop
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= 2'h0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      in_ready <= (count_next != 2'h2);
      out_valid <= (count_next != 2'h0);
    end
  end

  // Storage: head refills from slot 1 or straight from the input
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end
    else if (pop)
    begin
      // A full buffer never pushes, so slot 1 is the only candidate then
      if (count_reg == 2'h2)
        slot_reg[0] <= slot_reg[1];
      else if (push)
        slot_reg[0] <= in_data;
    end
    else if (push)
    begin
      if (count_reg == 2'h0)
        slot_reg[0] <= in_data;
      else
        slot_reg[1] <= in_data;
    end
  end
endmodule

// >>> test/csm_sink_model.sv
// Downstream result receiver model with commanded stalls
`timescale 1ns/100ps
module csm_sink_model (
  // Clock
  input wire logic ref_clk,
  // Result handshake
  input wire logic out_valid,
  output logic out_ready,
  // Stall mode: 0 always ready, 1 random stalls, 2 stalled
  input wire logic [1:0] stall_mode
);
  initial out_ready = 1'b0;
  // Ready moves off the sampling edge so the taking edge sees it settled
  always @(negedge ref_clk)
  begin
    case (stall_mode)
      2'h0: out_ready <= 1'b1;
      2'h1: out_ready <= (($urandom % 3) != 0);
      default: out_ready <= 1'b0;
    endcase
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the matrix multiplier: loads, stream, stalls, resets
`timescale 1ns/100ps
module testbench;
  // Clock, reset and stimulus
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [9:0] kp [3];
  logic [11:0] din [3];
  logic in_valid = 1'b0;
  logic in_ready, out_valid, out_ready;
  logic [11:0] res [3];
  logic [1:0] stall_mode = 2'h0;
  // Reference store [port][group] and queue of expected results
  logic [9:0] coef_m [3][3];
  logic [35:0] exp_q [$];
  int cyc_q [$];
  logic [35:0] e;
  int cyc, t, n, num_errors, cmp_count;
  logic lat_on;

  always #4 ref_clk = ~ref_clk;

  csm_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .coef_write_select(sel),
    .coef_port_first(kp[0]), .coef_port_second(kp[1]), .coef_port_third(kp[2]),
    .in_valid(in_valid), .in_ready(in_ready), .data_in_first(din[0]), .data_in_second(din[1]),
    .data_in_third(din[2]), .out_valid(out_valid), .out_ready(out_ready),
    .result_first(res[0]), .result_second(res[1]), .result_third(res[2]));

  csm_sink_model sink_u (.ref_clk(ref_clk), .out_valid(out_valid), .out_ready(out_ready),
    .stall_mode(stall_mode));

  // Signed dot product, half-up rounding of the 9 fraction bits, wrapping
  function automatic logic [11:0] rnd(input logic [11:0] a, b, c, input logic [9:0] x, y, z);
    int s;
    s = $signed(a) * $signed(x) + $signed(b) * $signed(y) + $signed(c) * $signed(z) + 256;
    return s[20:9];
  endfunction

  task chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task stop_test;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Offer one word with a load; hold it until the design takes it
  task send(input logic [1:0] s, input logic [9:0] k0, k1, k2, input logic [11:0] a, b, c);
    sel = s;
    kp = '{k0, k1, k2};
    din = '{a, b, c};
    in_valid = 1'b1;
    for (n = 0; n < 100 && in_ready !== 1'b1; n++) @(negedge ref_clk);
    if (in_ready !== 1'b1)
    begin
      num_errors++;
      stop_test();
    end
    @(negedge ref_clk);
  endtask

  task idle(input int k);
    sel = 2'h0;
    in_valid = 1'b0;
    repeat (k) @(negedge ref_clk);
  endtask

  // Reference model: load on the same edge that captures a word
  always @(posedge ref_clk)
  begin
    cyc++;
    if (!resetn)
    begin
      foreach (coef_m[p, g]) coef_m[p][g] = 10'h000;
      exp_q.delete();
      cyc_q.delete();
    end
    else
    begin
      if (sel != 2'h0)
        for (int p = 0; p < 3; p++) coef_m[p][sel - 2'h1] = kp[p];
      if (in_valid && in_ready)
      begin
        for (int o = 0; o < 3; o++)
          e[12 * o +: 12] = rnd(din[0], din[1], din[2], coef_m[0][o], coef_m[1][o], coef_m[2][o]);
        exp_q.push_back(e);
        cyc_q.push_back(cyc);
      end
      if (out_valid && out_ready)
      begin
        if (exp_q.size() == 0)
          chk("extra result", 36'h0, 36'h1);
        else
        begin
          chk("result", exp_q.pop_front(), {res[2], res[1], res[0]});
          t = cyc_q.pop_front();
          if (lat_on)
            chk("latency", 36'(csm_pkg::PIPE_LAT), 36'(cyc - t));
        end
      end
    end
  end

  // Watchdog against a hung run
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    kp = '{10'h000, 10'h000, 10'h000};
    din = '{12'h000, 12'h000, 12'h000};
    cyc = 0;
    num_errors = 0;
    cmp_count = 0;
    lat_on = 1'b0;
    void'($urandom(32'hc60c6821));
    repeat (4) @(negedge ref_clk);
    chk("reset outputs", 36'h0, {res[2], res[1], res[0]});
    chk("reset flags", 36'h0, {34'h0, in_ready, out_valid});
    resetn = 1'b1;
    stall_mode = 2'h0;
    @(negedge ref_clk);
    // Extreme coefficients and data in every group, then a hold with new port values
    send(2'h1, 10'h200, 10'h1ff, 10'h001, 12'h800, 12'h7ff, 12'h001);
    send(2'h2, 10'h1ff, 10'h200, 10'h3ff, 12'h7ff, 12'h800, 12'hfff);
    send(2'h3, 10'h100, 10'h080, 10'h200, 12'h800, 12'h800, 12'h800);
    send(2'h0, 10'h155, 10'h2aa, 10'h0f0, 12'h123, 12'h456, 12'h789);
    idle(10);
    lat_on = 1'b1;
    send(2'h0, 10'h000, 10'h000, 10'h000, 12'h3c5, 12'h9a1, 12'h07e);
    idle(10);
    lat_on = 1'b0;
    // Back-to-back random words and loads against a stalling receiver
    stall_mode = 2'h1;
    repeat (400)
      send(2'($urandom), 10'($urandom), 10'($urandom), 10'($urandom), 12'($urandom), 12'($urandom),
        12'($urandom));
    // Receiver stops: buffer fills and refuses, then drains
    stall_mode = 2'h2;
    sel = 2'h0;
    in_valid = 1'b1;
    for (n = 0; n < 30 && in_ready !== 1'b0; n++) @(negedge ref_clk);
    chk("refuse when full", 36'h0, {35'h0, in_ready});
    stall_mode = 2'h0;
    idle(30);
    chk("drained", 36'h0, 36'(exp_q.size()));
    chk("idle valid", 36'h0, {35'h0, out_valid});
    // Reset mid-stream clears the coefficient store
    send(2'h1, 10'h1ff, 10'h1ff, 10'h1ff, 12'h7ff, 12'h7ff, 12'h7ff);
    resetn = 1'b0;
    idle(2);
    chk("second reset", 36'h0, {res[2], res[1], res[0]});
    resetn = 1'b1;
    @(negedge ref_clk);
    send(2'h0, 10'h000, 10'h000, 10'h000, 12'h7ff, 12'h800, 12'h555);
    idle(12);
    chk("final drain", 36'h0, 36'(exp_q.size()));
    stop_test();
  end
endmodule
